/* File: otp_region_access.sv */
`include "otp_defs.svh"

module otp_region_access #(
   parameter logic [63:0] SN_LO_VALUE = 64'h0123456789ABCDEF // arbitrary value
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // serial link
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   output logic so,
   output logic so_oe_n,
   // array and pin side
   input wire logic program_accelerate_input,
   input wire logic array_busy,
   input wire logic erase_fail_set,
   // status
   output logic write_enable_latch,
   output logic write_in_progress_flag,
   output logic erase_fail_flag,
   output logic program_fail_flag,
   output logic otp_access,
   output logic accel_enable,
   output otp_pkg::otp_addr_t last_addr
);
   import otp_pkg::*;

   // ****************************************
   // helpers
   // ****************************************
   function automatic region_t region_of(input otp_addr_t a);
      otp_addr_t oa;
      otp_addr_t ob;
      region_t r;
      oa = a - `R16A_BASE;
      ob = a - `R16B_BASE;
      if (a >= `SN_LO_BASE && a < `SN_HI_BASE) begin
         r = `REG_SN_LO;
      end else if (a >= `SN_HI_BASE && a < `RLOCK_LO_ADDR) begin
         r = `REG_SN_HI;
      end else if (a >= `R16A_BASE && a <= `R16A_TOP) begin
         r = {1'b0, oa[8:4]} + `REG_R16A;
      end else if (a >= `R16B_BASE && a < `R10_BASE) begin
         r = {1'b0, ob[8:4]} + `REG_R16B;
      end else if (a >= `R10_BASE && a <= `OTP_TOP) begin
         r = `REG_R10;
      end else if (a == `SN_LOCK_ADDR || a == `RLOCK_LO_ADDR || a == `RLOCK_HI_ADDR ||
                   a == `XLOCK_LO_ADDR || a == `XLOCK_HI_ADDR) begin
         r = `REG_LOCKB;
      end else begin
         r = `REG_NONE;
      end
      return r;
   endfunction

   function automatic logic [8:0] idx_of(input otp_addr_t a);
      otp_addr_t d;
      d = a - `OTP_BASE;
      return d[8:0];
   endfunction

   function automatic logic [7:0] lock_mask(input otp_addr_t a);
      logic [7:0] m;
      m = `FULL_MASK;
      if (a == `SN_LOCK_ADDR) begin
         m = `SN_LOCK_MASK;
      end else if (a == `XLOCK_HI_ADDR) begin
         m = `XLOCK_HI_MASK;
      end
      return m;
   endfunction

   // ****************************************
   // input synchronisers
   // ****************************************
   logic [3:0] s1_r, s2_r, s3_r, f_r, f_nxt;
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_r <= `SYNC_RST;
         s2_r <= `SYNC_RST;
         s3_r <= `SYNC_RST;
         f_r <= `SYNC_RST;
      end else begin
         s1_r <= {program_accelerate_input, si, cs_n, sck};
         s2_r <= s1_r;
         s3_r <= s2_r;
         f_r <= f_nxt;
      end
   end
   // a level counts once the last two stages agree
   assign f_nxt = (s2_r & s3_r) | (f_r & (s2_r | s3_r));
   wire sck_rise = f_nxt[0] & ~f_r[0];
   wire sck_fall = ~f_nxt[0] & f_r[0];
   wire cs_fall = ~f_nxt[1] & f_r[1];
   wire cs_rise = f_nxt[1] & ~f_r[1];
   wire si_bit = f_nxt[2];
   wire acc_lvl = f_r[3];

   // ****************************************
   // otp array
   // ****************************************
   logic [7:0] mem [0:511];
   initial begin
      for (int i = 0; i < 512; i++) begin
         mem[i] = `ERASED_BYTE;
      end
      for (int i = 0; i < 8; i++) begin
         mem[idx_of(`SN_LO_BASE) + 9'(i)] = SN_LO_VALUE[63 - 8 * i -: 8];
      end
      mem[idx_of(`SN_LOCK_ADDR)] = `SN_LOCK_RST;
      mem[idx_of(`RLOCK_LO_ADDR)] = 8'h00;
      mem[idx_of(`RLOCK_HI_ADDR)] = 8'h00;
      mem[idx_of(`XLOCK_LO_ADDR)] = 8'h00;
      mem[idx_of(`XLOCK_HI_ADDR)] = 8'h00;
   end

   wire [32:0] lock_vec = {mem[idx_of(`XLOCK_HI_ADDR)][6:0], mem[idx_of(`XLOCK_LO_ADDR)],
                           mem[idx_of(`RLOCK_HI_ADDR)], mem[idx_of(`RLOCK_LO_ADDR)],
                           mem[idx_of(`SN_LOCK_ADDR)][1:0]};

   // ****************************************
   // command state
   // ****************************************
   cmd_state_t st_r;
   logic [7:0] opc_r, sh_r, tx_r, pd_r, tmr_r;
   logic [5:0] bitc_r;
   otp_addr_t addr_r, pa_r;
   logic wel_r, wip_r, efail_r, pfail_r, otp_r, accel_r, so_r, oe_n_r;

   wire [7:0] sh_nxt = {sh_r[6:0], si_bit};
   wire otp_blocked = array_busy | wip_r;
   wire opc_done = sck_rise && st_r == ST_OPC && bitc_r == 6'd7;
   wire opc_otp = sh_nxt == `OPC_OTP_PROG || sh_nxt == `OPC_OTP_READ;
   wire addr_done = sck_rise && st_r == ST_ADDR && bitc_r == 6'(`ADDR_BITS - 1);
   wire dummy_done = sck_rise && st_r == ST_DUMMY && bitc_r == 6'(`DUMMY_BITS - 1);
   wire read_reload = sck_rise && st_r == ST_READ && bitc_r == 6'd8;
   wire [23:0] addr_nxt = {addr_r[22:0], si_bit};
   wire [23:0] addr_inc = addr_r + 24'h000001;
   wire addr_in = addr_r >= `OTP_BASE && addr_r <= `OTP_TOP;
   wire [7:0] rd_byte = addr_in ? mem[idx_of(addr_r)] : `ERASED_BYTE;

   region_t p_reg;
   assign p_reg = region_of(addr_r);
   wire p_valid = p_reg != `REG_NONE;
   wire p_locked = p_reg != `REG_LOCKB && p_valid && lock_vec[p_reg[5:0]];
   wire prog_try = cs_rise && st_r == ST_PDATA && bitc_r == 6'd8;
   wire prog_go = prog_try && wel_r && !otp_blocked && p_valid && !p_locked;
   wire prog_lock_fail = prog_try && wel_r && !otp_blocked && p_locked;
   wire clr_go = cs_rise && st_r == ST_SKIP && opc_r == `OPC_FAIL_CLR && bitc_r == 6'd0;
   wire write_enable_cmd_go = cs_rise && st_r == ST_SKIP && opc_r == `OPC_WR_EN && bitc_r == 6'd0;

   // ****************************************
   // serial frame sequencer
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst || cs_rise) begin
         st_r <= ST_IDLE;
         otp_r <= 1'b0;
         oe_n_r <= 1'b1;
         so_r <= 1'b0;
         bitc_r <= 6'd0;
      end else if (cs_fall) begin
         st_r <= ST_OPC;
         bitc_r <= 6'd0;
      end else if (sck_rise) begin
         sh_r <= sh_nxt;
         bitc_r <= bitc_r + 6'd1;
         unique case (st_r)
            ST_OPC: begin
               if (opc_done) begin
                  opc_r <= sh_nxt;
                  bitc_r <= 6'd0;
                  st_r <= (opc_otp && !otp_blocked) ? ST_ADDR : ST_SKIP;
                  otp_r <= opc_otp && !otp_blocked;
               end
            end
            ST_ADDR: begin
               addr_r <= addr_nxt;
               if (addr_done) begin
                  bitc_r <= 6'd0;
                  st_r <= (opc_r == `OPC_OTP_PROG) ? ST_PDATA : ST_DUMMY;
               end
            end
            ST_PDATA: begin
               // saturate so any count past one byte stays invalid
               if (bitc_r > 6'd8) begin
                  bitc_r <= bitc_r;
               end
            end
            ST_DUMMY: begin
               if (dummy_done) begin
                  st_r <= ST_READ;
                  bitc_r <= 6'd0;
                  tx_r <= rd_byte;
                  addr_r <= addr_inc;
                  oe_n_r <= 1'b0;
               end
            end
            ST_READ: begin
               bitc_r <= bitc_r;
               if (read_reload) begin
                  bitc_r <= 6'd0;
                  tx_r <= rd_byte;
                  addr_r <= addr_inc;
               end
            end
            ST_IDLE, ST_SKIP: begin
               bitc_r <= (st_r == ST_SKIP) ? 6'd1 : 6'd0;
            end
         endcase
      end else if (sck_fall && st_r == ST_READ && bitc_r < 6'd8) begin
         so_r <= tx_r[7];
         tx_r <= {tx_r[6:0], 1'b1};
         bitc_r <= bitc_r + 6'd1;
      end
   end

   // ****************************************
   // program engine and status
   // ****************************************
   wire mem_we = wip_r && tmr_r == 8'h00;
   wire [7:0] mem_rd = mem[idx_of(pa_r)];
   wire lock_wr = region_of(pa_r) == `REG_LOCKB;
   // lock bytes set bits, data cells only clear them; nothing restores a one
   wire [7:0] mem_wd = lock_wr ? (mem_rd | (pd_r & lock_mask(pa_r)))
                               : (mem_rd & pd_r);

   // plain always: the power-on image above writes these cells too
   always @(posedge clk) begin
      if (mem_we) begin
         mem[idx_of(pa_r)] <= mem_wd;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wip_r <= 1'b0;
         tmr_r <= 8'h00;
         pa_r <= '0;
         pd_r <= 8'h00;
      end else if (prog_go) begin
         wip_r <= 1'b1;
         tmr_r <= 8'(`OTP_PROG_CYC - 1);
         pa_r <= addr_r;
         pd_r <= sh_r;
      end else if (wip_r) begin
         tmr_r <= tmr_r - 8'h01;
         wip_r <= tmr_r != 8'h00;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wel_r <= 1'b0;
         efail_r <= 1'b0;
         pfail_r <= 1'b0;
         accel_r <= 1'b0;
      end else begin
         if (mem_we) begin
            wel_r <= 1'b0;
         end else if (write_enable_cmd_go && !wip_r) begin
            wel_r <= 1'b1;
         end
         // event wins over a clear in the same cycle
         efail_r <= erase_fail_set | (efail_r & ~clr_go);
         pfail_r <= prog_lock_fail | (pfail_r & ~clr_go);
         accel_r <= acc_lvl & ~otp_r & ~(opc_done & opc_otp);
      end
   end

   assign so = so_r;
   assign so_oe_n = oe_n_r;
   assign write_enable_latch = wel_r;
   assign write_in_progress_flag = wip_r;
   assign erase_fail_flag = efail_r;
   assign program_fail_flag = pfail_r;
   assign otp_access = otp_r;
   assign accel_enable = accel_r;
   assign last_addr = addr_r;

   // ****************************************
   // checks
   // ****************************************
   property p_clr_fails;
      @(posedge clk) disable iff (rst)
      clr_go && !erase_fail_set |=> !efail_r && !pfail_r;
   endproperty
   a_clr_fails: assert property (p_clr_fails) else $error("fail flags not cleared");

   property p_clr_keeps_wel;
      @(posedge clk) disable iff (rst)
      clr_go && !mem_we |=> wel_r == $past(wel_r);
   endproperty
   a_clr_keeps_wel: assert property (p_clr_keeps_wel) else $error("clear moved latch");

   property p_prog_needs_wel;
      @(posedge clk) disable iff (rst)
      $rose(wip_r) |-> $past(wel_r) && $past(cs_rise);
   endproperty
   a_prog_needs_wel: assert property (p_prog_needs_wel) else $error("program w/o latch");

   property p_one_byte;
      @(posedge clk) disable iff (rst)
      $rose(wip_r) |-> $past(bitc_r) == 6'd8 && $past(st_r) == ST_PDATA;
   endproperty
   a_one_byte: assert property (p_one_byte) else $error("program with bad count");

   property p_no_set_cell;
      @(posedge clk) disable iff (rst)
      mem_we && !lock_wr |=> (mem_rd & ~$past(mem_rd)) == 8'h00;
   endproperty
   a_no_set_cell: assert property (p_no_set_cell) else $error("cell went to one");

   property p_lock_sticky;
      @(posedge clk) disable iff (rst)
      ##1 ($past(lock_vec) & ~lock_vec) == 33'h0;
   endproperty
   a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit cleared");

   property p_locked_ignored;
      @(posedge clk) disable iff (rst)
      prog_try && p_locked |=> !wip_r;
   endproperty
   a_locked_ignored: assert property (p_locked_ignored) else $error("locked programmed");

   property p_back_to_array;
      @(posedge clk) disable iff (rst)
      cs_rise |=> !otp_r && oe_n_r;
   endproperty
   a_back_to_array: assert property (p_back_to_array) else $error("otp mode kept");

   property p_no_accel;
      @(posedge clk) disable iff (rst)
      otp_r |-> !accel_r;
   endproperty
   a_no_accel: assert property (p_no_accel) else $error("accel during otp");

   property p_wip_len;
      @(posedge clk) disable iff (rst)
      $rose(wip_r) |-> ##124 wip_r ##1 (!wip_r && !wel_r);
   endproperty
   a_wip_len: assert property (p_wip_len) else $error("program time wrong");

   property p_busy_refused;
      @(posedge clk) disable iff (rst)
      opc_done && array_busy |=> !otp_r;
   endproperty
   a_busy_refused: assert property (p_busy_refused) else $error("otp while busy");
endmodule

/* File: otp_defs.svh */
`ifndef OTP_DEFS_SVH
`define OTP_DEFS_SVH

// ****************************************
// opcodes
// ****************************************
`define OPC_OTP_PROG 8'h42
`define OPC_OTP_READ 8'h4B
`define OPC_FAIL_CLR 8'h30
`define OPC_WR_EN 8'h06

// ****************************************
// otp address map
// ****************************************
`define OTP_BASE 24'h000100
`define OTP_TOP 24'h0002FF
`define SN_LOCK_ADDR 24'h000100
`define SN_LO_BASE 24'h000102
`define SN_HI_BASE 24'h00010A
`define RLOCK_LO_ADDR 24'h000112
`define RLOCK_HI_ADDR 24'h000113
`define R16A_BASE 24'h000114
`define R16A_TOP 24'h000213
`define XLOCK_LO_ADDR 24'h000214
`define XLOCK_HI_ADDR 24'h000215
`define R16B_BASE 24'h000216
`define R10_BASE 24'h0002F6

// ****************************************
// region codes and lock fields
// ****************************************
`define REG_SN_LO 6'h00
`define REG_SN_HI 6'h01
`define REG_R16A 6'h02
`define REG_R16B 6'h12
`define REG_R10 6'h20
`define REG_NONE 6'h3E
`define REG_LOCKB 6'h3F
`define SN_LOCK_MASK 8'h03
`define XLOCK_HI_MASK 8'h7F
`define FULL_MASK 8'hFF
`define SN_LOCK_RST 8'h01
`define ERASED_BYTE 8'hFF

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 8
`define OTP_PROG_NS 1000
`define OTP_PROG_CYC ((`OTP_PROG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_BITS 24
`define DUMMY_BITS 8
`define SYNC_RST 4'h2

`endif

/* File: otp_pkg.sv */
package otp_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_OPC, ST_ADDR, ST_PDATA, ST_DUMMY, ST_READ, ST_SKIP
   } cmd_state_t;
   typedef logic [5:0] region_t;
   typedef logic [23:0] otp_addr_t;
endpackage

/* File: spi_host.sv */
module spi_host (
   // system clock
   input wire logic clk,
   // serial link
   output logic sck,
   output logic cs_n,
   output logic si,
   input wire logic so
);
   timeunit 1ns;
   timeprecision 100ps;

   // ****************************************
   // frame engine, mode 0, clock parked low between frames
   // ****************************************
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end

   // released data line keeps toggling so a stale bit never looks valid
   always @(posedge clk) begin
      if (cs_n) begin
         si <= #1 ~si;
      end
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // ntx bits out msb first, then nrx bits in; so is taken late in the high
   // phase because the device answers through its input synchronisers
   task automatic xfer(input logic [63:0] tx, input int ntx, input int nrx,
                       output logic [63:0] rx);
      rx = '0;
      @(posedge clk);
      #1;
      cs_n = 1'b0;
      step(4);
      for (int i = ntx - 1; i >= -nrx; i--) begin
         if (i >= 0) begin
            si = tx[i];
         end else begin
            si = ~si;
         end
         step(5);
         sck = 1'b1;
         step(5);
         if (i < 0) begin
            rx = {rx[62:0], so};
         end
         sck = 1'b0;
      end
      step(5);
      cs_n = 1'b1;
      step(12);
   endtask
endmodule

/* File: testbench.sv */
`include "otp_defs.svh"

module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import otp_pkg::*;

   localparam logic [63:0] SN = 64'h0F1E2D3C4B5A6978; // arbitrary value
   logic clk, rst, sck, cs_n, si, so, so_oe_n;
   logic program_accelerate_input, array_busy, erase_fail_set;
   logic write_enable_latch, write_in_progress_flag, erase_fail_flag;
   logic program_fail_flag, otp_access, accel_enable;
   otp_addr_t last_addr;
   logic [63:0] rx;
   int n_fail, n_checks;

   otp_region_access #(.SN_LO_VALUE(SN)) dut_u (
      .clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
      .so_oe_n(so_oe_n), .program_accelerate_input(program_accelerate_input),
      .array_busy(array_busy), .erase_fail_set(erase_fail_set),
      .write_enable_latch(write_enable_latch),
      .write_in_progress_flag(write_in_progress_flag),
      .erase_fail_flag(erase_fail_flag), .program_fail_flag(program_fail_flag),
      .otp_access(otp_access), .accel_enable(accel_enable), .last_addr(last_addr)
   );

   // released output shows the inverse of its last level, so stale bits never pass
   wire so_line = so_oe_n ? ~so : so;
   spi_host host_u (.clk(clk), .sck(sck), .cs_n(cs_n), .si(si), .so(so_line));

   initial clk = 1'b0;
   always #4 clk = ~clk;

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%0h expected=%0h", $time, seen, exp);
      end
   endtask

   task automatic stop_test;
      $display("checks=%0d mismatches=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic wait_idle;
      int k;
      k = 0;
      while (write_in_progress_flag !== 1'b0 && k < 400) begin
         @(posedge clk);
         k++;
      end
      if (write_in_progress_flag !== 1'b0) begin
         n_fail++;
         stop_test();
      end
   endtask

   task automatic cmd(input logic [7:0] opc);
      host_u.xfer({56'h0, opc}, 8, 0, rx);
   endtask

   task automatic prog(input otp_addr_t a, input logic [7:0] d, input logic ok);
      cmd(`OPC_WR_EN);
      host_u.xfer({24'h0, `OPC_OTP_PROG, a, d}, 40, 0, rx);
      check(last_addr, a);
      if (ok) begin
         check(write_in_progress_flag, 1'b1);
      end
      wait_idle();
      if (ok) begin
         check(write_enable_latch, 1'b0);
      end
   endtask

   task automatic rd(input otp_addr_t a, input int n);
      host_u.xfer({24'h0, `OPC_OTP_READ, a, 8'h00}, 40, 8 * n, rx);
      check(otp_access, 1'b0);
   endtask

   task automatic rdc(input otp_addr_t a, input logic [7:0] e);
      rd(a, 1);
      check(rx[7:0], e);
   endtask

   task automatic efail_pulse;
      @(posedge clk) #1 erase_fail_set = 1'b1;
      @(posedge clk) #1 erase_fail_set = 1'b0;
      check(erase_fail_flag, 1'b1);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      n_fail = 0;
      n_checks = 0;
      rst = 1'b1;
      program_accelerate_input = 1'b0;
      array_busy = 1'b0;
      erase_fail_set = 1'b0;
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      repeat (8) @(posedge clk);
      check({so_oe_n, write_enable_latch, write_in_progress_flag, otp_access}, 4'h8);
      // clear with the latch still low must work and leave it low
      efail_pulse();
      cmd(`OPC_FAIL_CLR);
      check({erase_fail_flag, write_enable_latch}, 2'b00);
      rd(`SN_LO_BASE, 8);
      check(rx, SN);
      rdc(`SN_LOCK_ADDR, 8'h01);
      rdc(`RLOCK_HI_ADDR, 8'h00);
      // program with the latch clear must leave the cell erased
      host_u.xfer({24'h0, `OPC_OTP_PROG, `R16A_BASE, 8'h00}, 40, 0, rx);
      check(write_in_progress_flag, 1'b0);
      rdc(`R16A_BASE, 8'hFF);
      prog(`R16A_BASE, 8'hA5, 1'b1);
      rdc(`R16A_BASE, 8'hA5);
      prog(`R16A_BASE, 8'hF0, 1'b1);
      rdc(`R16A_BASE, 8'hA0);
      prog(`R16A_BASE, 8'hFF, 1'b1);
      rdc(`R16A_BASE, 8'hA0);
      cmd(`OPC_WR_EN);
      host_u.xfer({16'h0, `OPC_OTP_PROG, `R16A_BASE + 24'h1, 16'h0}, 48, 0, rx);
      wait_idle();
      rdc(`R16A_BASE + 24'h1, 8'hFF);
      prog(24'h001116, 8'h00, 1'b0);
      rdc(24'h000116, 8'hFF);
      prog(`SN_LO_BASE, 8'h00, 1'b0);
      rdc(`SN_LO_BASE, SN[63:56]);
      prog(`SN_HI_BASE, 8'h12, 1'b1);
      rdc(`SN_HI_BASE, 8'h12);
      prog(`SN_LOCK_ADDR, 8'hFF, 1'b1);
      rdc(`SN_LOCK_ADDR, 8'h03);
      prog(`SN_HI_BASE, 8'h00, 1'b0);
      rdc(`SN_HI_BASE, 8'h12);
      prog(`RLOCK_LO_ADDR, 8'h01, 1'b1);
      rdc(`RLOCK_LO_ADDR, 8'h01);
      prog(`R16A_BASE + 24'h3, 8'h00, 1'b0);
      rdc(`R16A_BASE + 24'h3, 8'hFF);
      check(program_fail_flag, 1'b1);
      prog(`R16A_BASE + 24'h10, 8'h00, 1'b1);
      rdc(`R16A_BASE + 24'h10, 8'h00);
      prog(`RLOCK_LO_ADDR, 8'h00, 1'b1);
      rdc(`RLOCK_LO_ADDR, 8'h01);
      prog(`XLOCK_HI_ADDR, 8'hFF, 1'b1);
      rdc(`XLOCK_HI_ADDR, 8'h7F);
      prog(24'h000296, 8'h00, 1'b0);
      rdc(24'h000296, 8'hFF);
      rd(`OTP_TOP - 24'h1, 3);
      check(rx[23:0], 24'hFFFFFF);
      // fail flags: clear works with the latch set and keeps it
      efail_pulse();
      cmd(`OPC_WR_EN);
      cmd(`OPC_FAIL_CLR);
      check({erase_fail_flag, program_fail_flag, write_enable_latch}, 3'b001);
      program_accelerate_input = 1'b1;
      repeat (8) @(posedge clk);
      check(accel_enable, 1'b1);
      fork
         rd(`R16A_BASE, 1);
         begin
            repeat (150) @(posedge clk);
            check({otp_access, accel_enable}, 2'b10);
         end
      join
      check(rx[7:0], 8'hA0);
      array_busy = 1'b1;
      fork
         rd(`R16A_BASE, 1);
         begin
            repeat (150) @(posedge clk);
            check(otp_access, 1'b0);
         end
      join
      stop_test();
   end

   initial begin
      repeat (90000) @(posedge clk);
      n_fail++;
      stop_test();
   end
endmodule
